// ---- rtl/arpc_port.sv ----
// Result port configuration: parallel bus, coding, modes and serial master
`timescale 1ns/1ps
`default_nettype none
`include "arpc_defs.svh"
// Contract
// - Swap high on upper half puts low byte there, else natural order.
// - Coding select high gives straight binary; low inverts the MSB.
// - Fast and rate-independent selects high give fast wideband mode.
// - Fast high, rate-independent low gives fast conversion mode.
// - Both selects low gives rate-independent mode.
// - Serial select high enables serial pins, other bus pins float.
// - Serial select low delivers results over the parallel bus.
// - Bus bits zero and one are always driven outputs.
// - In parallel mode bits two and three drive result data.
// - Master read-after-convert latches divider select; at the 50 ns clock every code gives the same 100 ns serial clock.
// - Divider codes give 8, 16, 32, 64 ns minimum clock period.
// - Other serial modes float the two divider select pins.
// - Clock source select low makes device master driving serial clock.
// - Read-during-conversion low outputs result only after conversion ends.
module arpc_port
   import arpc_pkg::*;
(
   // Clock and reset
   input wire logic clk_i,
   input wire logic sys_rst_i,
   // Static configuration pins
   input wire logic byte_order_swap_i,
   input wire logic output_coding_select_i,
   input wire logic fast_mode_select_i,
   input wire logic rate_indep_select_i,
   input wire logic interface_type_select_i,
   input wire logic serial_clock_source_select_i,
   input wire logic read_during_conversion_select_i,
   // Conversion result from the converter core
   input wire logic result_valid_i,
   input wire logic [15:0] result_i,
   // Data bus pins
   input wire logic [15:0] data_bus_i,
   output logic [15:0] data_bus_o,
   output logic [15:0] data_bus_oe_n_o,
   // Serial pins
   output logic serial_clock_o,
   output logic serial_clock_oe_n_o,
   output logic serial_result_out_o,
   output logic serial_sync_o,
   // Status
   output logic [1:0] conv_mode_o,
   output logic serial_busy_o
);
   logic [15:0] sync1_q, sync2_q;
   logic [6:0] cfg1_q, cfg2_q;
   logic rv1_q, rv2_q, rv3_q;
   logic [15:0] word_q;
   wire swap, bin_sel, fast, rind, ser_sel, ext_clk, rd_conv;
   wire master_rac;
   wire [15:0] coded;
   wire [15:0] par_word;
   wire [15:0] oe_n_d;
   wire [15:0] out_d;
   wire rv_rise;
   arpc_mode_type mode;
   arpc_ser_if ser();

   // Pins come from outside the clock domain
   always_ff @(posedge clk_i or posedge sys_rst_i)
   begin
      if (sys_rst_i)
      begin
         sync1_q <= 16'h0000;
         sync2_q <= 16'h0000;
         cfg1_q <= 7'h00;
         cfg2_q <= 7'h00;
         rv1_q <= 1'b0;
         rv2_q <= 1'b0;
         rv3_q <= 1'b0;
      end
      else
      begin
         sync1_q <= data_bus_i;
         sync2_q <= sync1_q;
         cfg1_q <= {byte_order_swap_i, output_coding_select_i,
            fast_mode_select_i, rate_indep_select_i, interface_type_select_i,
            serial_clock_source_select_i, read_during_conversion_select_i};
         cfg2_q <= cfg1_q;
         rv1_q <= result_valid_i;
         rv2_q <= rv1_q;
         rv3_q <= rv2_q;
      end
   end

   assign {swap, bin_sel, fast, rind, ser_sel, ext_clk, rd_conv} = cfg2_q;
   assign rv_rise = rv2_q & ~rv3_q;

   // Conversion mode decode
   assign mode = arpc_mode_type'({fast, rind});

   // Output coding
   assign coded = {result_i[`ARPC_MSB] ^ ~bin_sel, result_i[14:0]};

   // Byte order on parallel bus
   assign par_word = swap ? {word_q[7:0], word_q[15:8]} : word_q;

   assign master_rac = ser_sel & ~ext_clk & ~rd_conv;

   // Serial pin use: D0/D1 always out, D2/D3 out only in parallel mode
   assign oe_n_d = ser_sel ? 16'hFFFC : 16'h0000;
   assign out_d = ser_sel ? {14'h0000, ser.sdo, ser.sync} : par_word;

   assign ser.start = rv_rise & master_rac;
   assign ser.word = coded;
   assign ser.div_sel = sync2_q[3:2];

   always_ff @(posedge clk_i or posedge sys_rst_i)
   begin
      if (sys_rst_i)
         word_q <= 16'h0000;
      else if (rv_rise)
         word_q <= coded;
   end

   always_ff @(posedge clk_i or posedge sys_rst_i)
   begin
      if (sys_rst_i)
      begin
         data_bus_o <= 16'h0000;
         data_bus_oe_n_o <= 16'h0000;
         serial_clock_o <= 1'b0;
         serial_clock_oe_n_o <= 1'b1;
         serial_result_out_o <= 1'b0;
         serial_sync_o <= 1'b0;
         conv_mode_o <= 2'h0;
         serial_busy_o <= 1'b0;
      end
      else
      begin
         data_bus_o <= out_d;
         data_bus_oe_n_o <= oe_n_d;
         serial_clock_o <= ser.sclk;
         serial_clock_oe_n_o <= ~(ser_sel & ~ext_clk);
         serial_result_out_o <= ser.sdo;
         serial_sync_o <= ser.sync;
         conv_mode_o <= mode;
         serial_busy_o <= ser.busy;
      end
   end

   arpc_shifter i_arpc_shifter
   (
      .clk_i(clk_i),
      .sys_rst_i(sys_rst_i),
      .ser(ser)
   );

   low_bits_out_a: assert property (@(posedge clk_i) disable iff (sys_rst_i)
      data_bus_oe_n_o[1:0] == 2'b00)
      else $error("bus bits zero and one not driven");
   serial_float_a: assert property (@(posedge clk_i) disable iff (sys_rst_i)
      ser_sel |=> data_bus_oe_n_o[15:2] == 14'h3FFF)
      else $error("unused bus pin driven in serial mode");
   div_float_a: assert property (@(posedge clk_i) disable iff (sys_rst_i)
      ser_sel && !master_rac |=> data_bus_oe_n_o[3:2] == 2'b11)
      else $error("divider pins driven outside read after convert");
   parallel_drive_a: assert property (@(posedge clk_i) disable iff (sys_rst_i)
      !ser_sel |=> data_bus_oe_n_o == 16'h0000)
      else $error("parallel bus not fully driven");
   par_bits_a: assert property (@(posedge clk_i) disable iff (sys_rst_i)
      !ser_sel |=> data_bus_o[3:2] == $past(par_word[3:2]))
      else $error("result bits two and three wrong");
   byte_swap_a: assert property (@(posedge clk_i) disable iff (sys_rst_i)
      !ser_sel && swap |=> data_bus_o[15:8] == $past(word_q[7:0]))
      else $error("low byte not on upper half when swapped");
   coding_a: assert property (@(posedge clk_i) disable iff (sys_rst_i)
      rv_rise |=> word_q[15] == ($past(result_i[15]) ^ ~$past(bin_sel)))
      else $error("output coding of msb wrong");
   mode_wide_a: assert property (@(posedge clk_i) disable iff (sys_rst_i)
      fast && rind |=> conv_mode_o == ARPC_MODE_WIDE)
      else $error("wideband fast mode not selected");
   mode_fast_a: assert property (@(posedge clk_i) disable iff (sys_rst_i)
      fast && !rind |=> conv_mode_o == ARPC_MODE_FAST)
      else $error("fast mode not selected");
   mode_norm_a: assert property (@(posedge clk_i) disable iff (sys_rst_i)
      !fast && !rind |=> conv_mode_o == ARPC_MODE_NORMAL)
      else $error("rate independent mode not selected");
   master_clk_a: assert property (@(posedge clk_i) disable iff (sys_rst_i)
      ser_sel && !ext_clk |=> !serial_clock_oe_n_o)
      else $error("master serial clock not driven");
   after_conv_a: assert property (@(posedge clk_i) disable iff (sys_rst_i)
      ser.start |-> rv_rise && !rd_conv)
      else $error("serial read started before conversion end");
   div_use_a: assert property (@(posedge clk_i) disable iff (sys_rst_i)
      ser.start |-> ser.div_sel == sync2_q[3:2])
      else $error("divider select not taken from pins");
   mode_odd_a: assert property (@(posedge clk_i) disable iff (sys_rst_i)
      !fast && rind |=> conv_mode_o == ARPC_MODE_ODD)
      else $error("odd mode code not reported");
   ser_pins_a: assert property (@(posedge clk_i) disable iff (sys_rst_i)
      ser_sel |=> data_bus_o[1:0] == $past({ser.sdo, ser.sync}))
      else $error("serial pins not on bus bits zero and one");
   par_word_a: assert property (@(posedge clk_i) disable iff (sys_rst_i)
      !ser_sel |=> data_bus_o == $past(par_word))
      else $error("parallel word not on bus");
   natural_order_a: assert property (@(posedge clk_i) disable iff (sys_rst_i)
      !ser_sel && !swap |=> data_bus_o == $past(word_q))
      else $error("natural byte order not kept");
   slave_clk_a: assert property (@(posedge clk_i) disable iff (sys_rst_i)
      !(ser_sel && !ext_clk) |=> serial_clock_oe_n_o)
      else $error("serial clock driven outside master mode");
   capture_a: assert property (@(posedge clk_i) disable iff (sys_rst_i)
      rv_rise |=> word_q == $past(coded))
      else $error("result word not captured");
   no_start_a: assert property (@(posedge clk_i) disable iff (sys_rst_i)
      ser_sel && (ext_clk || rd_conv) |-> !ser.start)
      else $error("serial frame started outside read after convert");
endmodule
`default_nettype wire

// ---- inc/arpc_defs.svh ----
// Constants for the result port configuration block
`ifndef ARPC_DEFS_SVH
`define ARPC_DEFS_SVH
`define ARPC_DATA_W 16
`define ARPC_CLK_PERIOD_NS 50
`define ARPC_SCLK_MIN_NS_0 8
`define ARPC_SCLK_MIN_NS_1 16
`define ARPC_SCLK_MIN_NS_2 32
`define ARPC_SCLK_MIN_NS_3 64
`define ARPC_SCLK_CYC(ns) (((ns) + `ARPC_CLK_PERIOD_NS - 1) / `ARPC_CLK_PERIOD_NS)
`define ARPC_SCLK_HALF_W 4
`define ARPC_BIT_CNT_W 5
`define ARPC_LAST_BIT 5'h0F
`define ARPC_MSB 15
`endif

// ---- inc/arpc_pkg.sv ----
// Types for the result port configuration block
package arpc_pkg;
   typedef enum logic [1:0]
   {
      ARPC_MODE_NORMAL = 2'b00,
      ARPC_MODE_FAST = 2'b10,
      ARPC_MODE_WIDE = 2'b11,
      ARPC_MODE_ODD = 2'b01
   } arpc_mode_type;
   typedef enum logic [1:0]
   {
      ARPC_SH_IDLE = 2'b00,
      ARPC_SH_LOW = 2'b01,
      ARPC_SH_HIGH = 2'b10
   } arpc_shift_type;
endpackage

// ---- inc/arpc_ser_if.sv ----
// Carrier between port logic and the serial shifter
`timescale 1ns/1ps
`default_nettype none
interface arpc_ser_if;
   logic start;
   logic [15:0] word;
   logic [1:0] div_sel;
   logic sclk;
   logic sdo;
   logic sync;
   logic busy;
   modport ctrl (output start, output word, output div_sel,
      input sclk, input sdo, input sync, input busy);
   modport shift (input start, input word, input div_sel,
      output sclk, output sdo, output sync, output busy);
endinterface
`default_nettype wire

// ---- rtl/arpc_shifter.sv ----
// Master serial shifter with selectable clock divider
`timescale 1ns/1ps
`default_nettype none
`include "arpc_defs.svh"
module arpc_shifter
   import arpc_pkg::*;
(
   // Clock and reset
   input wire logic clk_i,
   input wire logic sys_rst_i,
   // Link to port logic
   arpc_ser_if.shift ser
);
   arpc_shift_type st_q, st_d;
   logic [`ARPC_SCLK_HALF_W-1:0] cnt_q;
   logic [`ARPC_BIT_CNT_W-1:0] bit_q;
   logic [15:0] sh_q;
   logic [1:0] div_q;
   wire [`ARPC_SCLK_HALF_W-1:0] half_len;
   wire half_done;

   // Half period from divider code, at least one cycle
   function automatic logic [`ARPC_SCLK_HALF_W-1:0] half_cyc(
      input logic [1:0] code);
      logic [31:0] ns;
      ns = 32'd0;
      unique case (code)
         2'b00: ns = `ARPC_SCLK_MIN_NS_0;
         2'b01: ns = `ARPC_SCLK_MIN_NS_1;
         2'b10: ns = `ARPC_SCLK_MIN_NS_2;
         2'b11: ns = `ARPC_SCLK_MIN_NS_3;
      endcase
      half_cyc = `ARPC_SCLK_HALF_W'(`ARPC_SCLK_CYC(ns / 2));
      if (half_cyc == '0)
         half_cyc = `ARPC_SCLK_HALF_W'(1);
   endfunction

   assign half_len = half_cyc(div_q);
   assign half_done = (cnt_q == half_len - `ARPC_SCLK_HALF_W'(1));

   always_comb
   begin
      st_d = st_q;
      unique case (st_q)
         ARPC_SH_IDLE: if (ser.start) st_d = ARPC_SH_LOW;
         ARPC_SH_LOW: if (half_done) st_d = ARPC_SH_HIGH;
         ARPC_SH_HIGH:
            if (half_done)
               st_d = (bit_q == `ARPC_LAST_BIT) ? ARPC_SH_IDLE : ARPC_SH_LOW;
         default: st_d = ARPC_SH_IDLE;
      endcase
   end

   always_ff @(posedge clk_i or posedge sys_rst_i)
   begin
      if (sys_rst_i)
      begin
         st_q <= ARPC_SH_IDLE;
         cnt_q <= '0;
         bit_q <= '0;
         sh_q <= '0;
         div_q <= 2'h0;
      end
      else
      begin
         st_q <= st_d;
         cnt_q <= (st_q == ARPC_SH_IDLE || half_done) ? '0 : cnt_q + 1'b1;
         if (st_q == ARPC_SH_IDLE && ser.start)
         begin
            sh_q <= ser.word;
            div_q <= ser.div_sel;
            bit_q <= '0;
         end
         else if (st_q == ARPC_SH_HIGH && half_done)
         begin
            sh_q <= {sh_q[14:0], 1'b0};
            bit_q <= bit_q + 1'b1;
         end
      end
   end

   assign ser.sclk = (st_q == ARPC_SH_HIGH);
   assign ser.sdo = sh_q[15];
   assign ser.sync = (st_q != ARPC_SH_IDLE);
   assign ser.busy = (st_q != ARPC_SH_IDLE);

   sclk_period_a: assert property (@(posedge clk_i) disable iff (sys_rst_i)
      $rose(ser.sclk) |-> ser.sclk [*1] ##0 (cnt_q == '0))
      else $error("serial clock high phase did not restart count");
   clk_in_frame_a: assert property (@(posedge clk_i) disable iff (sys_rst_i)
      ser.sclk |-> ser.sync)
      else $error("serial clock high outside a frame");
   frame_len_a: assert property (@(posedge clk_i) disable iff (sys_rst_i)
      $fell(ser.busy) |-> bit_q == `ARPC_LAST_BIT + 5'h01)
      else $error("serial frame did not hold sixteen bits");
endmodule
`default_nettype wire

// ---- test/arpc_host_model.sv ----
// Host side model that reads master serial frames from the result port
`timescale 1ns/1ps
`default_nettype none
module arpc_host_model
(
   // Serial pins from the port
   input wire logic sclk_i,
   input wire logic sdo_i,
   input wire logic sync_i,
   // Last frame as seen by the host
   output logic [15:0] word_o,
   output int bits_o,
   output int period_o
);
   realtime last_t;
   initial
   begin
      word_o = 16'h0000;
      bits_o = 0;
      period_o = 0;
      last_t = 0;
   end
   // Frame start clears the count; rising serial clock samples, MSB first
   always @(posedge sync_i or posedge sclk_i)
   begin
      if (sync_i === 1'b1 && sclk_i !== 1'b1)
         bits_o = 0;
      else if (sync_i === 1'b1)
      begin
         if (bits_o > 0)
            period_o = int'($realtime - last_t);
         last_t = $realtime;
         word_o = {word_o[14:0], sdo_i};
         bits_o = bits_o + 1;
      end
   end
endmodule
`default_nettype wire

// ---- test/adc_result_port_config_bench.sv ----
// Self-checking bench for the result port configuration block
`timescale 1ns/1ps
`default_nettype none
module adc_result_port_config_bench;
   import arpc_pkg::*;
   logic clk = 1'b0, rst = 1'b1, swap = 1'b0, coding = 1'b1, fast = 1'b0;
   logic rind = 1'b0, ser = 1'b0, src = 1'b0, rd_conv = 1'b0, rv = 1'b0;
   logic [1:0] div = 2'h0;
   logic [15:0] res = 16'h0000, seed = 16'h2F89, w, bus_i, bus_o, oe_n;
   logic sclk, sclk_oe_n, sdo, sync, busy;
   logic [1:0] mode;
   logic [15:0] hword;
   int hbits, hper, error_cnt = 0, n_checks = 0, b0, k, hp;
   int frames = 0;
   logic [1:0] mtab [4] = '{2'h0, 2'h2, 2'h3, 2'h1};
   // Host drives only the divider pins; driven pins read back their own value
   assign bus_i = (bus_o & ~oe_n) | ({12'h000, div, 2'h0} & oe_n);
   always #25 clk = ~clk;
   // Counts serial frames as the host sees them start
   always @(posedge sync) frames++;
   function automatic logic [15:0] lfsr_next(input logic [15:0] s);
      lfsr_next = {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
   endfunction
   arpc_port i_arpc_port (.clk_i(clk), .sys_rst_i(rst),
      .byte_order_swap_i(swap), .output_coding_select_i(coding),
      .fast_mode_select_i(fast), .rate_indep_select_i(rind),
      .interface_type_select_i(ser), .serial_clock_source_select_i(src),
      .read_during_conversion_select_i(rd_conv), .result_valid_i(rv),
      .result_i(res), .data_bus_i(bus_i), .data_bus_o(bus_o),
      .data_bus_oe_n_o(oe_n), .serial_clock_o(sclk),
      .serial_clock_oe_n_o(sclk_oe_n), .serial_result_out_o(sdo),
      .serial_sync_o(sync), .conv_mode_o(mode), .serial_busy_o(busy));
   arpc_host_model i_arpc_host_model (.sclk_i(sclk), .sdo_i(sdo),
      .sync_i(sync), .word_o(hword), .bits_o(hbits), .period_o(hper));
   task automatic check(input logic [15:0] seen, input logic [15:0] exp);
      n_checks++;
      if (seen !== exp)
      begin
         $display("CHECK FAILED at %0t: got %h want %h", $time, seen, exp);
         error_cnt++;
      end
   endtask
   task automatic complete_run();
      $display("checks %0d mismatches %0d", n_checks, error_cnt);
      if (error_cnt == 0 && n_checks > 0)
         $display("RESULT: PASS");
      else
         $display("RESULT: FAIL");
      $finish;
   endtask
   // Config changes only between conversions, then lets the sync settle
   task automatic settle();
      repeat (6) @(negedge clk);
   endtask
   // Conversions follow closely, well inside the fast-mode interval
   task automatic conv();
      seed = lfsr_next(seed);
      res = seed;
      w = coding ? res : res ^ 16'h8000;
      rv = 1'b1;
      repeat (8) @(negedge clk);
      rv = 1'b0;
      k = 0;
      while (busy !== 1'b0 && k < 100)
      begin
         @(negedge clk);
         k++;
         if (ser)
            check({14'h0, bus_o[1:0]}, {14'h0, sdo, sync});
      end
      if (k == 100)
      begin
         error_cnt++;
         complete_run();
      end
      repeat (3) @(negedge clk);
   endtask
   initial
   begin
      repeat (8) @(negedge clk);
      rst = 1'b0;
      for (int i = 0; i < 16; i++)
      begin
         swap = i[0];
         coding = i[1];
         {fast, rind} = mtab[i / 4];
         settle();
         conv();
         check(bus_o, swap ? {w[7:0], w[15:8]} : w);
         check(oe_n, 16'h0000);
         check({14'h0, mode}, {14'h0, mtab[i / 4]});
      end
      $display("parallel test done");
      ser = 1'b1;
      for (int c = 0; c < 4; c++)
      begin
         div = c[1:0];
         coding = c[0];
         settle();
         b0 = frames;
         conv();
         hp = ((8 << c) / 2 + 49) / 50;
         hp = (hp < 1) ? 1 : hp;
         check(oe_n, 16'hFFFC);
         check({15'h0, sclk_oe_n}, 16'h0000);
         check(hword, w);
         check(16'(hbits), 16'd16);
         check(16'(hper), 16'(2 * hp * 50));
         check({15'h0, hper >= (8 << c)}, 16'h0001);
         check(16'(frames), 16'(b0 + 1));
      end
      $display("serial master test done");
      for (int j = 0; j < 2; j++)
      begin
         src = ~j[0];
         rd_conv = j[0];
         settle();
         b0 = frames;
         conv();
         check(16'(frames), 16'(b0));
         check(oe_n, 16'hFFFC);
         check({15'h0, sclk_oe_n}, {15'h0, src});
      end
      $display("serial other modes test done");
      complete_run();
   end
endmodule
`default_nettype wire
